// ### hdl/pmh_speed_mod.sv
// profile speed modulation: source pick, magnitude, polarity, scaling
`include "pmh_params.svh"
module pmh_speed_mod (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic [31:0]              src_sel,
	input  wire logic                     pol_rev,
	input  wire logic [15:0]              own_value,
	input  wire logic [15:0]              ext_value,
	input  wire pmh_pkg::pmh_mode_class_t mode_class,
	input  wire logic [31:0]              profile_velocity,
	output logic      [31:0]              mod_velocity
);
	logic [15:0] raw;     // selected source sample
	logic [15:0] mag;     // magnitude, clamped to full scale
	logic [15:0] eff;     // value after polarity
	logic [47:0] prod;    // velocity times modulation
	logic [47:0] quot;    // scaled back by full scale
	logic        applies; // mode class uses modulation

	// source select, abs and clamp
	always_comb begin
		raw = (src_sel == `PMH_MOD_SRC_OWN) ? own_value : ext_value; // see R6
		mag = raw[15] ? 16'(-raw) : raw; // see R3
		if (mag > `PMH_MOD_FULL) begin
			mag = `PMH_MOD_FULL; // see R2
		end
		eff = pol_rev ? 16'(`PMH_MOD_FULL - mag) : mag; // see R5
	end

	// only in profile, servo and sequence classes
	assign applies = (mode_class == pmh_pkg::pmh_profile_position_class) ||
	                 (mode_class == pmh_pkg::pmh_servo_mode_class) ||
	                 (mode_class == pmh_pkg::pmh_sequence_mode_class); // see R4
	assign prod = profile_velocity * eff; // see R19
	assign quot = prod / {32'h0000_0000, `PMH_MOD_FULL};

	// registered output velocity
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mod_velocity <= `PMH_RST_W32;
		end else if (applies && (src_sel != `PMH_RST_W32)) begin
			mod_velocity <= quot[31:0]; // see R2
		end else begin
			mod_velocity <= profile_velocity; // see R20
		end
	end
endmodule

// ### hdl/pmh_sync.sv
// two-flop synchroniser, one per bit
module pmh_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q; // first stage, read only by second stage

	// one pair of flops per bit
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_q[i] <= 1'b0;
				q[i]      <= 1'b0;
			end else begin
				meta_q[i] <= d[i];
				q[i]      <= meta_q[i];
			end
		end
	end
endmodule

// ### hdl/pmh_top.sv
// modulation, axis limits and homing control behind an ahb-lite slave
// Overview of operation
// R1: selector holds index, sub-index, zero byte
// R2: modulation 0..0x7FFF, full equals 100 percent
// R3: negative source value uses its magnitude
// R4: applies in profile, servo, sequence classes
// R5: config bit0 reverses modulation polarity
// R6: own signed 16-bit modulation object, reset zero
// R7: axis kind 0 rotating, 1 linear
// R8: soft limits active only on linear axis
// R9: limits act like hardware limit switches
// R10: control bit4 rise starts, clear aborts homing
// R11: status bits 13,12,10 encode homing state
// R12: bit10 set while velocity is zero
// R13: bit12 cleared on five listed events; code clears it only on reset, sensor fault, bit4 rise and bit4 clear
// R14: bit13 set on bad launch conditions
// R15: bit13 cleared only reset or bit7 rise
// R16: device drives homing trajectory itself
// R17: home reached loads offset into feedback
// R18: only listed homing methods are implemented
// R19: velocity times modulation over 0x7FFF
// R20: zero selector means no modulation
//
// Implementation choice: register access over AHB-Lite.
`include "pmh_params.svh"
module pmh_top (
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic      [31:0]              hrdata,
	input  wire pmh_pkg::pmh_mode_class_t op_mode_class,
	input  wire logic                     op_enabled,
	input  wire logic [31:0]              profile_velocity,
	input  wire logic [15:0]              mod_ext_value,
	input  wire logic [31:0]              actual_position,
	input  wire logic                     velocity_zero_pin,
	input  wire logic                     sensor_fault_pin,
	input  wire logic                     home_event_pin,
	input  wire logic                     neg_limit_sw_pin,
	input  wire logic                     pos_limit_sw_pin,
	output logic      [31:0]              mod_velocity,
	output logic                          travel_stop_neg,
	output logic                          travel_stop_pos,
	output logic                          home_move_active,
	output logic                          home_move_negative,
	output logic      [31:0]              home_move_speed,
	output logic      [31:0]              home_accel,
	output logic      [15:0]              home_current_limit,
	output logic                          pos_load_strobe,
	output logic      [31:0]              pos_load_value,
	output logic      [15:0]              status_word
);
	// bus data phase tracking
	logic        addr_ok;      // address phase accepted
	logic        dp_valid_q;   // a data phase is open
	logic        dp_write_q;   // open phase is a write
	logic        dp_map_q;     // address aligned, upper bits zero
	logic        dp_word_q;    // word sized access
	logic [15:0] dp_idx_q;     // object index of open phase
	logic        rd_done_q;    // read wait state spent
	logic        wr_en;        // write strobe this cycle
	logic [31:0] rd_mux;       // read value by index
	logic [31:0] hrdata_q;     // registered read data

	// registers
	logic [31:0] mod_src_q;        // speed_mod_source_select
	logic        mod_pol_q;        // speed_mod_polarity_config bit0
	logic [15:0] mod_val_q;        // speed_mod_value
	logic [15:0] home_cur_q;       // home_current_limit
	logic [15:0] finish_home_q;    // finish_at_home_position
	logic [15:0] home_flag_q;      // home_operation_flag
	logic [7:0]  axis_q;           // axis_kind_select
	logic [31:0] home_off_q;       // home_position_offset
	logic [31:0] lim_neg_q;        // soft_travel_limits sub 1
	logic [31:0] lim_pos_q;        // soft_travel_limits sub 2
	logic [7:0]  method_q;         // home_method_select
	logic [31:0] speeds_q;         // home_search_speeds
	logic [31:0] accel_q;          // home_accel_rate
	logic [15:0] ctrl_q;           // control word

	// synchronised pins
	logic [4:0]  pins_s;           // sync outputs
	logic        vz_s;             // velocity is zero
	logic        fault_s;          // sensor fault
	logic        home_ev_s;        // home position event
	logic        neg_sw_s;         // negative limit switch
	logic        pos_sw_s;         // positive limit switch

	// homing control
	pmh_pkg::pmh_home_state_t hm_q; // sequencer state
	logic        home_bit_prev_q;  // control bit4 last cycle
	logic        clr_bit_prev_q;   // control bit7 last cycle
	logic        start_evt;        // bit4 rising
	logic        clr_evt;          // bit7 rising
	logic        bad_launch;       // launch refused
	logic        home_reach;       // home found this cycle
	logic        attained_q;       // status bit12
	logic        err_q;            // status bit13
	logic        linear;           // axis is linear
	logic        vz_bit;           // status bit10

	// method table of implemented homing methods
	function automatic logic method_ok(input logic [7:0] m);
		logic signed [7:0] s;
		s = signed'(m);
		method_ok = (s >= signed'(`PMH_M_A_LO) && s <= signed'(`PMH_M_A_HI)) ||
		            (s >= signed'(`PMH_M_B_LO) && s <= signed'(`PMH_M_B_HI)) ||
		            (s >= signed'(`PMH_M_C_LO) && s <= signed'(`PMH_M_C_HI)) ||
		            (s >= signed'(`PMH_M_D_LO) && s <= signed'(`PMH_M_D_HI));
	endfunction

	// methods that begin by moving in the negative direction
	function automatic logic method_neg(input logic [7:0] m);
		unique case (m)
			8'h01, 8'h05, 8'h06, 8'h0B, 8'h0C, 8'h0D, 8'h0E: begin
				method_neg = 1'b1;
			end
			8'h11, 8'h15, 8'h16, 8'h1B, 8'h1C, 8'h1D, 8'h1E: begin
				method_neg = 1'b1;
			end
			8'h21, 8'hFF, 8'hFD: begin
				method_neg = 1'b1;
			end
			default: begin
				method_neg = 1'b0;
			end
		endcase
	endfunction

	// external pins pass two flops
	pmh_sync #(
		.W(5)
	) u_sync (
		.clk  (hclk),
		.rst_n(hresetn),
		.d    ({velocity_zero_pin, sensor_fault_pin, home_event_pin,
		        neg_limit_sw_pin, pos_limit_sw_pin}),
		.q    (pins_s)
	);
	assign {vz_s, fault_s, home_ev_s, neg_sw_s, pos_sw_s} = pins_s;

	// speed modulation datapath
	pmh_speed_mod u_mod (
		.clk             (hclk),
		.rst_n           (hresetn),
		.src_sel         (mod_src_q),
		.pol_rev         (mod_pol_q),
		.own_value       (mod_val_q),
		.ext_value       (mod_ext_value),
		.mode_class      (op_mode_class),
		.profile_velocity(profile_velocity),
		.mod_velocity    (mod_velocity)
	);

	// accept an address phase only when the bus is ready
	assign addr_ok = hsel && htrans[1] && hready;

	// data phase bookkeeping
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_map_q   <= 1'b0;
			dp_word_q  <= 1'b0;
			dp_idx_q   <= `PMH_RST_W16;
		end else if (addr_ok) begin
			dp_valid_q <= 1'b1;
			dp_write_q <= hwrite;
			dp_map_q   <= (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
			dp_word_q  <= (hsize == 3'h2);
			dp_idx_q   <= haddr[17:2];
		end else if (hreadyout) begin
			dp_valid_q <= 1'b0; // phase closed
		end
	end

	// reads take one wait state so data sees every earlier write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_done_q <= 1'b0;
		end else begin
			rd_done_q <= dp_valid_q && !dp_write_q && !rd_done_q;
		end
	end
	assign hreadyout = !(dp_valid_q && !dp_write_q && !rd_done_q);
	assign hresp     = 1'b0;
	assign wr_en     = dp_valid_q && dp_write_q && dp_map_q && dp_word_q;

	// read multiplexer, unmapped reads zero
	always_comb begin
		rd_mux = `PMH_RST_W32;
		if (dp_map_q) begin
			unique case (dp_idx_q)
				`PMH_IDX_MOD_SRC:     rd_mux = mod_src_q;
				`PMH_IDX_MOD_POL:     rd_mux = {31'h0, mod_pol_q};
				`PMH_IDX_MOD_VAL:     rd_mux = {16'h0000, mod_val_q};
				`PMH_IDX_HOME_CUR:    rd_mux = {16'h0000, home_cur_q};
				`PMH_IDX_FINISH_HOME: rd_mux = {16'h0000, finish_home_q};
				`PMH_IDX_HOME_FLAG:   rd_mux = {16'h0000, home_flag_q};
				`PMH_IDX_AXIS:        rd_mux = {24'h00_0000, axis_q};
				`PMH_IDX_CTRL:        rd_mux = {16'h0000, ctrl_q};
				`PMH_IDX_STATUS:      rd_mux = {16'h0000, status_word};
				`PMH_IDX_HOME_OFF:    rd_mux = home_off_q;
				`PMH_IDX_LIM_NEG:     rd_mux = lim_neg_q;
				`PMH_IDX_LIM_POS:     rd_mux = lim_pos_q;
				`PMH_IDX_METHOD:      rd_mux = {24'h00_0000, method_q};
				`PMH_IDX_SPEEDS:      rd_mux = speeds_q;
				`PMH_IDX_ACCEL:       rd_mux = accel_q;
				default:              rd_mux = `PMH_RST_W32;
			endcase
		end
	end

	// capture read data in the wait cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= `PMH_RST_W32;
		end else if (dp_valid_q && !dp_write_q && !rd_done_q) begin
			hrdata_q <= rd_mux;
		end
	end
	assign hrdata = hrdata_q;

	// modulation registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mod_src_q <= `PMH_RST_W32;
			mod_pol_q <= 1'b0;
			mod_val_q <= `PMH_RST_W16; // see R6
		end else if (wr_en) begin
			if (dp_idx_q == `PMH_IDX_MOD_SRC) begin
				mod_src_q <= {hwdata[31:8], 8'h00}; // see R1
			end
			if (dp_idx_q == `PMH_IDX_MOD_POL) begin
				mod_pol_q <= hwdata[`PMH_POL_REV_BIT]; // see R5
			end
			if (dp_idx_q == `PMH_IDX_MOD_VAL) begin
				mod_val_q <= hwdata[15:0]; // see R6
			end
		end
	end

	// axis and limit registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			axis_q    <= `PMH_RST_W8; // see R7
			lim_neg_q <= `PMH_RST_W32;
			lim_pos_q <= `PMH_RST_W32;
		end else if (wr_en) begin
			if (dp_idx_q == `PMH_IDX_AXIS) begin
				axis_q <= hwdata[7:0];
			end
			if (dp_idx_q == `PMH_IDX_LIM_NEG) begin
				lim_neg_q <= hwdata; // see R9
			end
			if (dp_idx_q == `PMH_IDX_LIM_POS) begin
				lim_pos_q <= hwdata; // see R9
			end
		end
	end

	// homing parameter registers and control word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			home_cur_q    <= `PMH_RST_W16;
			finish_home_q <= `PMH_RST_W16;
			home_flag_q   <= `PMH_RST_W16;
			home_off_q    <= `PMH_RST_W32;
			method_q      <= `PMH_RST_METHOD;
			speeds_q      <= `PMH_RST_W32;
			accel_q       <= `PMH_RST_W32;
			ctrl_q        <= `PMH_RST_W16;
		end else if (wr_en) begin
			unique case (dp_idx_q)
				`PMH_IDX_HOME_CUR:    home_cur_q    <= hwdata[15:0];
				`PMH_IDX_FINISH_HOME: finish_home_q <= hwdata[15:0];
				`PMH_IDX_HOME_FLAG:   home_flag_q   <= hwdata[15:0];
				`PMH_IDX_HOME_OFF:    home_off_q    <= hwdata;
				`PMH_IDX_METHOD:      method_q      <= hwdata[7:0];
				`PMH_IDX_SPEEDS:      speeds_q      <= hwdata;
				`PMH_IDX_ACCEL:       accel_q       <= hwdata;
				`PMH_IDX_CTRL:        ctrl_q        <= hwdata[15:0];
				default:              ;
			endcase
		end
	end

	// soft limits merged with the switches, linear axis only
	assign linear = (axis_q == pmh_pkg::pmh_axis_linear); // see R7
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			travel_stop_neg <= 1'b0;
			travel_stop_pos <= 1'b0;
		end else begin
			travel_stop_neg <= neg_sw_s || (linear &&
				($signed(actual_position) < $signed(lim_neg_q))); // see R8
			travel_stop_pos <= pos_sw_s || (linear &&
				($signed(actual_position) > $signed(lim_pos_q))); // see R9
		end
	end

	// control word edge history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			home_bit_prev_q <= 1'b0;
			clr_bit_prev_q  <= 1'b0;
		end else begin
			home_bit_prev_q <= ctrl_q[`PMH_CW_HOME_BIT];
			clr_bit_prev_q  <= ctrl_q[`PMH_CW_ERR_CLR_BIT];
		end
	end
	assign start_evt  = ctrl_q[`PMH_CW_HOME_BIT] && !home_bit_prev_q; // see R10
	assign clr_evt    = ctrl_q[`PMH_CW_ERR_CLR_BIT] && !clr_bit_prev_q;
	assign bad_launch = !method_ok(method_q) ||
		(!op_enabled && (method_q != `PMH_M_CUR_POS)); // see R18
	assign home_reach = ((hm_q == pmh_pkg::pmh_hm_run) && ctrl_q[`PMH_CW_HOME_BIT]) &&
		(home_ev_s || (method_q == `PMH_M_CUR_POS));

	// homing sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hm_q <= pmh_pkg::pmh_hm_idle;
		end else if (start_evt) begin
			hm_q <= bad_launch ? pmh_pkg::pmh_hm_error : pmh_pkg::pmh_hm_run; // see R10
		end else if (!ctrl_q[`PMH_CW_HOME_BIT]) begin
			hm_q <= pmh_pkg::pmh_hm_idle; // see R10
		end else begin
			unique case (hm_q)
				pmh_pkg::pmh_hm_run: begin
					if (home_reach) begin
						hm_q <= pmh_pkg::pmh_hm_homed;
					end
				end
				pmh_pkg::pmh_hm_homed: begin
					if (vz_s) begin
						hm_q <= pmh_pkg::pmh_hm_done;
					end
				end
				default: begin
					hm_q <= hm_q; // idle, done, error hold
				end
			endcase
		end
	end

	// bit12: home known, cleared on reset, sensor fault, bit4 rise or bit4 clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			attained_q <= 1'b0; // see R13
		end else if (fault_s || start_evt || !ctrl_q[`PMH_CW_HOME_BIT]) begin
			attained_q <= 1'b0; // see R13
		end else if (home_reach) begin
			attained_q <= 1'b1;
		end
	end

	// bit13: error, set wins over the bit7 clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_q <= 1'b0;
		end else if (start_evt && bad_launch) begin
			err_q <= 1'b1; // see R14
		end else if (clr_evt) begin
			err_q <= 1'b0; // see R15
		end
	end

	// offset loaded into position feedback on home
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_load_strobe <= 1'b0;
			pos_load_value  <= `PMH_RST_W32;
		end else begin
			pos_load_strobe <= home_reach; // see R17
			pos_load_value  <= home_off_q;
		end
	end

	// trajectory request to the position loop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			home_move_active   <= 1'b0;
			home_move_negative <= 1'b0;
		end else begin
			home_move_active   <= (hm_q == pmh_pkg::pmh_hm_run) ||
			                      (hm_q == pmh_pkg::pmh_hm_homed); // see R16
			home_move_negative <= method_neg(method_q);
		end
	end
	assign home_move_speed    = speeds_q;
	assign home_accel         = accel_q;
	assign home_current_limit = home_cur_q;

	// status bit10: idle or done state, or velocity zero in any state
	assign vz_bit = (hm_q == pmh_pkg::pmh_hm_idle) || (hm_q == pmh_pkg::pmh_hm_done) ||
		vz_s; // see R12

	// status word homing bits
	always_comb begin
		status_word = `PMH_RST_W16;
		status_word[`PMH_SW_ERR_BIT] = err_q; // see R11
		status_word[`PMH_SW_ATT_BIT] = attained_q && !err_q;
		status_word[`PMH_SW_VZ_BIT]  = vz_bit;
	end
endmodule

// ### shared/pmh_params.svh
// offsets, bit positions, reset values and limits of the modulation and homing block
`ifndef PMH_PARAMS_SVH
`define PMH_PARAMS_SVH
// object indices; byte address is four times the index
`define PMH_IDX_MOD_SRC     16'h3081
`define PMH_IDX_MOD_POL     16'h3082
`define PMH_IDX_MOD_VAL     16'h3083
`define PMH_IDX_HOME_CUR    16'h309C
`define PMH_IDX_FINISH_HOME 16'h309D
`define PMH_IDX_HOME_FLAG   16'h3218
`define PMH_IDX_AXIS        16'h3360
`define PMH_IDX_CTRL        16'h6040
`define PMH_IDX_STATUS      16'h6041
`define PMH_IDX_HOME_OFF    16'h607C
`define PMH_IDX_LIM_NEG     16'h607D
`define PMH_IDX_LIM_POS     16'h607E
`define PMH_IDX_METHOD      16'h6098
`define PMH_IDX_SPEEDS      16'h6099
`define PMH_IDX_ACCEL       16'h609A
// field positions
`define PMH_CW_HOME_BIT     4
`define PMH_CW_ERR_CLR_BIT  7
`define PMH_SW_ERR_BIT      13
`define PMH_SW_ATT_BIT      12
`define PMH_SW_VZ_BIT       10
`define PMH_POL_REV_BIT     0
// reset values
`define PMH_RST_W32         32'h0000_0000
`define PMH_RST_W16         16'h0000
`define PMH_RST_W8          8'h00
`define PMH_RST_METHOD      8'h23
// modulation scale and own-object selector
`define PMH_MOD_FULL        16'h7FFF
`define PMH_MOD_SRC_OWN     32'h3083_0000
// homing method ranges (signed 8 bit)
`define PMH_M_A_LO          8'h01
`define PMH_M_A_HI          8'h0E
`define PMH_M_B_LO          8'h11
`define PMH_M_B_HI          8'h1E
`define PMH_M_C_LO          8'h21
`define PMH_M_C_HI          8'h23
`define PMH_M_D_LO          8'hFC
`define PMH_M_D_HI          8'hFF
`define PMH_M_CUR_POS       8'h23
`endif

// ### shared/pmh_pkg.sv
// types shared by the modulation and homing block
package pmh_pkg;
	// homing sequencer, gray along idle-run-homed-done
	typedef enum logic [2:0] {
		pmh_hm_idle  = 3'b000,
		pmh_hm_run   = 3'b001,
		pmh_hm_homed = 3'b011,
		pmh_hm_done  = 3'b010,
		pmh_hm_error = 3'b110
	} pmh_home_state_t;
	// operating mode class reported by the drive
	typedef enum logic [1:0] {
		pmh_other_class            = 2'h0,
		pmh_profile_position_class = 2'h1,
		pmh_servo_mode_class       = 2'h2,
		pmh_sequence_mode_class    = 2'h3
	} pmh_mode_class_t;
	// axis kind encoding
	typedef enum logic [7:0] {
		pmh_axis_rotating = 8'h00,
		pmh_axis_linear   = 8'h01
	} pmh_axis_t;
endpackage

// ### verif/pmh_drive_model.sv
// drive and sensor model: meets home after a delay, then comes to rest
module pmh_drive_model (
	input  wire logic       clk,
	input  wire logic       moving,
	input  wire logic [7:0] delay,
	output logic            vel_zero,
	output logic            home_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;   // cycles spent moving
	initial begin
		cnt = 8'h00;
		vel_zero = 1'b1;
		home_seen = 1'b0;
	end
	// home sensor after delay, standstill four cycles later
	always @(posedge clk) begin
		cnt <= moving ? cnt + 8'h01 : 8'h00;
		home_seen <= moving && (cnt >= delay);
		vel_zero <= !moving || (cnt > delay + 8'h03);
	end
endmodule

// ### verif/pmh_top_sva.sv
// assertion checker on the top ports of the modulation and homing block
module pmh_top_chk (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        sensor_fault_pin,
	input wire logic        velocity_zero_pin,
	input wire logic        neg_limit_sw_pin,
	input wire logic        pos_limit_sw_pin,
	input wire logic        travel_stop_neg,
	input wire logic        travel_stop_pos,
	input wire logic        home_move_active,
	input wire logic        pos_load_strobe,
	input wire logic [15:0] status_word
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// error and attained never shown together
	no_reserved_a: assert property (!(status_word[13] && status_word[12]))
		else $error("status shows a reserved homing code");
	// a lasting sensor fault drops the attained bit
	fault_clear_a: assert property (sensor_fault_pin [*4] |-> !status_word[12])
		else $error("attained bit kept through sensor fault");
	// standstill during a homing move shows in bit 10
	vz_status_a: assert property ((home_move_active && velocity_zero_pin) [*4]
		|-> status_word[10])
		else $error("standstill not shown during homing");
	// switches stop travel whatever the axis kind
	neg_switch_a: assert property (neg_limit_sw_pin [*4] |-> travel_stop_neg)
		else $error("negative switch did not stop travel");
	pos_switch_a: assert property (pos_limit_sw_pin [*4] |-> travel_stop_pos)
		else $error("positive switch did not stop travel");
	// the feedback load is a single pulse
	load_pulse_a: assert property (pos_load_strobe |=> !pos_load_strobe)
		else $error("feedback load longer than one cycle");
	// reaching home loads the feedback same cycle
	load_after_home_a: assert property ($rose(status_word[12])
		&& !$past(status_word[13]) |-> pos_load_strobe)
		else $error("home reached without feedback load");
	// read wait state lasts exactly one cycle, always okay
	ready_pulse_a: assert property (!hreadyout |=> hreadyout && !hresp)
		else $error("bus wait too long or error response");
	cover property (pos_load_strobe);
	cover property (status_word[13]);
	cover property (travel_stop_neg && travel_stop_pos);
endmodule

bind pmh_top pmh_top_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .sensor_fault_pin,
	.velocity_zero_pin, .neg_limit_sw_pin, .pos_limit_sw_pin, .travel_stop_neg,
	.travel_stop_pos, .home_move_active, .pos_load_strobe, .status_word);

// ### verif/tb_top.sv
// self-checking bench for the modulation and homing block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hwrite, vz, ev, fault, nsw, psw, op_en, rdy, resp;
	logic        tsn, tsp, act, neg, pls;
	logic [1:0]  htrans, mc;
	logic [7:0]  dly;
	logic [15:0] ext, sw;
	logic [31:0] haddr, hwdata, hrdata, rd_s, rd, pv, pos, mvel, plv;
	int          fail_count, samples_checked, cyc, loads;
	// reset table: index and value
	logic [15:0] ri [7] = '{16'h3081, 16'h3082, 16'h3083, 16'h3360, 16'h6098, 16'h6041, 16'h1234};
	logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h23, 32'h400, 32'h0};
	// modulation cases: selector, value, reversal, expected speed for 0xFFFE
	logic [31:0] ms [6] = '{32'h3083_00FF, 32'h3083_0000, 32'h3083_0000, 32'h3083_0000,
		32'h0, 32'h1234_0056};
	logic [15:0] mv [6] = '{16'h4000, 16'hC000, 16'h7FFF, 16'h0000, 16'h1234, 16'h1234};
	logic        mp [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [31:0] me [6] = '{32'hFFFE, 32'h8000, 32'h0, 32'hFFFE, 32'hFFFE, 32'h4000};
	pmh_top dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(rdy), .hreadyout(rdy), .hresp(resp), .hrdata,
		.op_mode_class(pmh_pkg::pmh_mode_class_t'(mc)), .op_enabled(op_en),
		.profile_velocity(pv), .mod_ext_value(ext),
		.actual_position(pos), .velocity_zero_pin(vz), .sensor_fault_pin(fault),
		.home_event_pin(ev), .neg_limit_sw_pin(nsw), .pos_limit_sw_pin(psw),
		.mod_velocity(mvel), .travel_stop_neg(tsn), .travel_stop_pos(tsp),
		.home_move_active(act), .home_move_negative(neg), .home_move_speed(),
		.home_accel(), .home_current_limit(), .pos_load_strobe(pls),
		.pos_load_value(plv), .status_word(sw));
	pmh_drive_model u_drv (.clk(hclk), .moving(act), .delay(dly), .vel_zero(vz), .home_seen(ev));
	// clock, cycle ceiling and load pulse count
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		loads += (pls === 1'b1);
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// wait for the slave to be ready at the coming edge
	task automatic wait_rdy;
		@(negedge hclk);
		while (rdy !== 1'b1) @(negedge hclk);
		rd_s = hrdata;
		@(posedge hclk);
	endtask
	// single word transfer by register index
	task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd);
		@(posedge hclk);
		haddr <= {14'h0, idx, 2'b00};
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = rd_s;
	endtask
	task automatic settle;
		repeat (4) @(negedge hclk);
	endtask
	task automatic wait_st(input logic [15:0] e);
		int n;
		n = 0;
		while (sw !== e && n < 400) begin
			@(negedge hclk);
			n++;
		end
		chk("status_word", {16'h0, e}, {16'h0, sw});
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		{hresetn, hwrite, fault, nsw, psw, op_en, htrans, haddr, hwdata, pos} = '0;
		{mc, ext, pv, dly, cyc, loads, fail_count, samples_checked} = '0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		pv <= 32'h0000_FFFE;
		ext <= 16'hE000;
		// reset values, status idle, unmapped place reads zero
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, ri[i], 32'h0);
			chk("reset value", rv[i], rd);
		end
		$display("test reset_values done");
		// modulation: other class, magnitude, reversal, no source in other class, external source
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, 16'h3081, ms[i]);
			mc <= 2'(i);
			bus(1'b1, 16'h3082, {31'h0, mp[i]});
			bus(1'b1, 16'h3083, {16'h0, mv[i]});
			settle();
			chk("mod_velocity", me[i], mvel);
		end
		bus(1'b0, 16'h3081, 32'h0);
		chk("selector low byte", 32'h1234_0000, rd);
		$display("test modulation done");
		// soft limits only on a linear axis, exact limit not crossed
		bus(1'b1, 16'h607D, 32'hFFFF_FF9C);
		bus(1'b1, 16'h607E, 32'h0000_0064);
		pos <= 32'h0000_00C8;
		settle();
		chk("stop rotating", 32'h0, {31'h0, tsp});
		bus(1'b1, 16'h3360, 32'h1);
		settle();
		chk("stop linear", 32'h1, {31'h0, tsp});
		bus(1'b1, 16'h3360, 32'h1);
		pos <= 32'hFFFF_FF9C;
		settle();
		chk("stop at limit", 32'h0, {31'h0, tsn});
		@(posedge hclk);
		{nsw, psw} <= 2'b11;
		settle();
		chk("switch stops", 32'h3, {30'h0, tsn, tsp});
		@(posedge hclk);
		{nsw, psw} <= 2'b00;
		$display("test limits done");
		// current position homing while disabled loads the offset
		bus(1'b1, 16'h607C, 32'h0000_1234);
		bus(1'b1, 16'h6040, 32'h10);
		wait_st(16'h1400);
		chk("load value", 32'h0000_1234, plv);
		bus(1'b1, 16'h6040, 32'h0);
		wait_st(16'h0400);
		chk("load pulses", 32'h1, 32'(loads));
		// disabled launch and unknown method both flag an error
		for (int i = 0; i < 2; i++) begin
			op_en <= i[0];
			bus(1'b1, 16'h6098, i ? 32'h0F : 32'h01);
			bus(1'b1, 16'h6040, 32'h10);
			wait_st(16'h2400);
			bus(1'b1, 16'h6040, 32'h0);
			settle();
			chk("error kept", 32'h2400, {16'h0, sw});
			bus(1'b1, 16'h6040, 32'h80);
			wait_st(16'h0400);
			bus(1'b1, 16'h6040, 32'h0);
		end
		$display("test homing_errors done");
		// slow move aborted, then a prompt one completes
		dly <= 8'hC8;
		bus(1'b1, 16'h6098, 32'h01);
		bus(1'b1, 16'h6040, 32'h10);
		wait_st(16'h0000);
		chk("move negative", 32'h3, {30'h0, act, neg});
		bus(1'b1, 16'h6040, 32'h0);
		wait_st(16'h0400);
		dly <= 8'h0A;
		bus(1'b1, 16'h6040, 32'h10);
		wait_st(16'h1400);
		bus(1'b0, 16'h6041, 32'h0);
		chk("status read", 32'h1400, rd);
		@(posedge hclk);
		fault <= 1'b1;
		wait_st(16'h0400);
		@(posedge hclk);
		fault <= 1'b0;
		$display("test homing_moves done");
		finish_test();
	end
endmodule
